/* File: rtl/sdc_defines.vh */
/*
 Constants for the segment descriptor checker: register byte offsets,
 descriptor field positions, type codes, exception vectors, reset values.
 Assumes it is included once per design file, by its bare name.
*/
`ifndef SDC_DEFINES_VH
`define SDC_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SDC_OFS_DESC_LO 8'h00
`define SDC_OFS_DESC_HI 8'h04
`define SDC_OFS_CTRL 8'h08
`define SDC_OFS_TGT_HI 8'h0C
`define SDC_OFS_OFFSET 8'h10
`define SDC_OFS_STATUS 8'h14
`define SDC_OFS_BASE 8'h18
`define SDC_OFS_LIMIT 8'h1C
`define SDC_OFS_WBACK 8'h20
`define SDC_OFS_STKLIM 8'h24

// ----------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------
`define SDC_CTRL_START 0
`define SDC_CTRL_IN_GLOBAL 1
`define SDC_CTRL_IS_WRITE 2
`define SDC_CTRL_AS_STACK 3
`define SDC_CTRL_PRIV_CHANGE 4
`define SDC_CTRL_WIDTH 5

// ----------------------------------------------------------------
// High descriptor word fields
// ----------------------------------------------------------------
`define SDC_HI_GRAN 23
`define SDC_HI_DSIZE 22
`define SDC_HI_PRESENT 15
`define SDC_HI_CLASS 12
`define SDC_HI_EXEC 11
`define SDC_HI_DIRCONF 10
`define SDC_HI_WRRD 9
`define SDC_HI_ACCESSED 8

// ----------------------------------------------------------------
// System type codes, exception vectors, stack ceilings, page fill and reset word
// ----------------------------------------------------------------
`define SDC_T_INVALID0 4'h0
`define SDC_T_TSS16_AVL 4'h1
`define SDC_T_LOCAL_TABLE 4'h2
`define SDC_T_TSS16_BUSY 4'h3
`define SDC_T_CALL16 4'h4
`define SDC_T_TASK_GATE 4'h5
`define SDC_T_INT16 4'h6
`define SDC_T_TRAP16 4'h7
`define SDC_T_INVALID8 4'h8
`define SDC_T_TSS32_AVL 4'h9
`define SDC_T_TSS32_BUSY 4'hB
`define SDC_T_CALL32 4'hC
`define SDC_T_RESERVED 4'hD
`define SDC_T_INT32 4'hE
`define SDC_T_TRAP32 4'hF
`define SDC_VEC_NOT_PRESENT 5'h0B
`define SDC_VEC_PROTECTION 5'h0D
`define SDC_STK_LIMIT_WIDE 32'hFFFF_FFFF
`define SDC_STK_LIMIT_NARROW 32'h0000_FFFF
`define SDC_PAGE_FILL 12'hFFF
`define SDC_RESET_WORD 32'h0000_0000

`endif

/* File: rtl/sdc_segment_descriptor_checker.v */
/*
 Segment descriptor checker: an APB slave that takes a descriptor (and,
 for gates, the access word of the destination descriptor), decodes its
 attributes and reports sizes, permissions, limits and the fault to raise.
 Assumes an APB master on mclk; software supplies the descriptor words
 fetched from the tables and writes back the accessed-flag word itself.
*/
`include "sdc_defines.vh"

module sdc_segment_descriptor_checker (
    input wire mclk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr
);

    // ----------------------------------------------------------------
    // Type decode helpers
    // ----------------------------------------------------------------
    function isTssType;
        input [3:0] t;
        begin
            isTssType = (t == `SDC_T_TSS16_AVL) || (t == `SDC_T_TSS16_BUSY) ||
                        (t == `SDC_T_TSS32_AVL) || (t == `SDC_T_TSS32_BUSY);
        end
    endfunction

    function isBadType;
        input [3:0] t;
        begin
            isBadType = (t == `SDC_T_INVALID0) || (t == `SDC_T_INVALID8) ||
                        (t == `SDC_T_RESERVED);
        end
    endfunction

    // Code descriptor test, used on the descriptor and on the gate's destination
    function isCodeWord;
        input [31:0] w;
        begin
            isCodeWord = w[`SDC_HI_CLASS] & w[`SDC_HI_EXEC];
        end
    endfunction

    // Registers are one aligned word each, up to the stack ceiling word
    function isMapped;
        input [7:0] a;
        begin
            isMapped = (a[1:0] == 2'b00) && (a <= `SDC_OFS_STKLIM);
        end
    endfunction

    // Page granularity fills the low 12 bits so the limit covers the last page
    function [31:0] scaleLimit;
        input [19:0] l;
        input g;
        begin
            scaleLimit = g ? {l, `SDC_PAGE_FILL} : {12'h000, l};
        end
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [31:0] descLo_ff;
    reg [31:0] descHi_ff;
    reg [31:0] tgtHi_ff;
    reg [31:0] offset_ff;
    reg [`SDC_CTRL_WIDTH-1:0] ctrl_ff;
    reg startPend_ff;
    reg [31:0] status_ff;
    reg [31:0] base_ff;
    reg [31:0] limit_ff;
    reg [31:0] wback_ff;
    reg [31:0] stkLim_ff;

    wire accessEdge = psel & penable & pready;
    wire wrEdge = accessEdge & pwrite;
    wire mapped = isMapped(paddr);
    // First access cycle of a transfer: the cycle that schedules pready
    wire firstAccess = psel & penable & ~pready;

    // ----------------------------------------------------------------
    // Field extraction
    // ----------------------------------------------------------------
    wire [3:0] dType = descHi_ff[11:8];
    wire isSeg = descHi_ff[`SDC_HI_CLASS];
    wire isCode = isCodeWord(descHi_ff);
    wire isData = isSeg & ~descHi_ff[`SDC_HI_EXEC];
    wire present = descHi_ff[`SDC_HI_PRESENT];
    wire gran = descHi_ff[`SDC_HI_GRAN];
    wire legacy = (descHi_ff[31:16] == 16'h0000);
    wire inGlobal = ctrl_ff[`SDC_CTRL_IN_GLOBAL];
    wire isWrite = ctrl_ff[`SDC_CTRL_IS_WRITE];
    wire asStack = ctrl_ff[`SDC_CTRL_AS_STACK];
    wire privChange = ctrl_ff[`SDC_CTRL_PRIV_CHANGE];

    // Base and limit; legacy system descriptors carry 24/16 bits only
    wire [31:0] base32 = {descHi_ff[31:24], descHi_ff[7:0], descLo_ff[31:16]};
    wire [31:0] base24 = {8'h00, descHi_ff[7:0], descLo_ff[31:16]};
    wire [19:0] lim20 = {descHi_ff[19:16], descLo_ff[15:0]};
    wire [31:0] limLegacy = {16'h0000, descLo_ff[15:0]};
    wire useLegacy = ~isSeg & legacy;
    wire [31:0] effBase = useLegacy ? base24 : base32;
    wire [31:0] effLimit = useLegacy ? limLegacy : scaleLimit(lim20, gran);

    // ----------------------------------------------------------------
    // System and gate classification (class flag clear)
    // ----------------------------------------------------------------
    wire isSys = ~isSeg;
    wire isLocalTbl = isSys & (dType == `SDC_T_LOCAL_TABLE);
    wire isTss = isSys & isTssType(dType);
    wire isCall = isSys & ((dType == `SDC_T_CALL16) || (dType == `SDC_T_CALL32));
    wire isTaskGate = isSys & (dType == `SDC_T_TASK_GATE);
    wire isIntGate = isSys & ((dType == `SDC_T_INT16) || (dType == `SDC_T_INT32));
    wire isTrapGate = isSys & ((dType == `SDC_T_TRAP16) || (dType == `SDC_T_TRAP32));
    wire isGate = isCall | isTaskGate | isIntGate | isTrapGate;
    wire badType = isSys & isBadType(dType);
    wire wide = isSys & dType[3];

    // Destination checks read the access word of the target descriptor
    wire [3:0] tgtType = tgtHi_ff[11:8];
    wire tgtCode = isCodeWord(tgtHi_ff);
    wire tgtTss = ~tgtHi_ff[`SDC_HI_CLASS] & isTssType(tgtType);
    wire destBad = (isTaskGate & ~tgtTss) | ((isCall | isIntGate | isTrapGate) & ~tgtCode);

    // ----------------------------------------------------------------
    // Segment permissions
    // ----------------------------------------------------------------
    wire writable = isData & descHi_ff[`SDC_HI_WRRD];
    wire readable = isData | (isCode & descHi_ff[`SDC_HI_WRRD]);
    wire conforming = isCode & descHi_ff[`SDC_HI_DIRCONF];
    wire expandDown = isData & descHi_ff[`SDC_HI_DIRCONF];
    wire bigFlag = descHi_ff[`SDC_HI_DSIZE];
    // Expand-down legal range is any offset above the limit; the stack ceiling is not checked
    wire offsetOk = expandDown ? (offset_ff > effLimit) : (offset_ff <= effLimit);
    wire writeBad = isWrite & ~writable;
    wire stackBad = asStack & ~writable;
    wire rangeBad = isSeg & ~offsetOk;
    wire tableBad = isLocalTbl & ~inGlobal;
    wire [4:0] wordCount = descHi_ff[4:0];
    wire [4:0] paramCount = (isCall & privChange) ? wordCount : 5'h00;

    // Fault priority: bad type or wrong table, then presence, then use checks
    reg fault;
    reg [4:0] vector;
    always @* begin
        fault = 1'b1;
        vector = `SDC_VEC_PROTECTION;
        if (badType | tableBad) begin
            vector = `SDC_VEC_PROTECTION;
        end else if (~present) begin
            vector = `SDC_VEC_NOT_PRESENT;
        end else if (isGate & destBad) begin
            vector = `SDC_VEC_PROTECTION;
        end else if (isSeg & (writeBad | stackBad | rangeBad)) begin
            vector = `SDC_VEC_PROTECTION;
        end else begin
            fault = 1'b0;
            vector = 5'h00;
        end
    end

    // Status word layout
    wire [31:0] nxt_status = {
        1'b0, // 31 spare
        vector, // 30:26 exception vector, zero when clean
        3'b000, // 25:23 spare
        paramCount, // 22:18
        1'b0, // 17 spare
        wide, // 16 32-bit system type
        isTaskGate, // 15
        isLocalTbl, // 14
        isTss, // 13
        isGate, // 12
        ~isTaskGate, // 11 offset field used
        offsetOk, // 10
        useLegacy, // 9
        isIntGate, // 8 enable flag clears on entry, trap gates keep it
        isSeg & bigFlag, // 7 wide stack pointer
        isCode, // 6
        readable, // 5
        writable, // 4
        conforming, // 3
        isSeg & bigFlag, // 2 32-bit operands and addressing
        fault, // 1
        1'b1 // 0 done
    };

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    reg [31:0] nxt_prdata;
    always @* begin
        case (paddr)
            `SDC_OFS_DESC_LO: nxt_prdata = descLo_ff;
            `SDC_OFS_DESC_HI: nxt_prdata = descHi_ff;
            `SDC_OFS_CTRL: nxt_prdata = {27'h000_0000, ctrl_ff[`SDC_CTRL_WIDTH-1:1], startPend_ff};
            `SDC_OFS_TGT_HI: nxt_prdata = tgtHi_ff;
            `SDC_OFS_OFFSET: nxt_prdata = offset_ff;
            `SDC_OFS_STATUS: nxt_prdata = status_ff;
            `SDC_OFS_BASE: nxt_prdata = base_ff;
            `SDC_OFS_LIMIT: nxt_prdata = limit_ff;
            `SDC_OFS_WBACK: nxt_prdata = wback_ff;
            `SDC_OFS_STKLIM: nxt_prdata = stkLim_ff;
            default: nxt_prdata = `SDC_RESET_WORD;
        endcase
    end

    // One wait state: pready rises in the second access cycle
    // Writes to result registers are dropped without error; only bad addresses err
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `SDC_RESET_WORD;
        end else begin
            pready <= firstAccess;
            pslverr <= firstAccess & ~mapped;
            if (firstAccess & ~pwrite) begin
                prdata <= nxt_prdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            descLo_ff <= `SDC_RESET_WORD;
            descHi_ff <= `SDC_RESET_WORD;
            tgtHi_ff <= `SDC_RESET_WORD;
            offset_ff <= `SDC_RESET_WORD;
            ctrl_ff <= {`SDC_CTRL_WIDTH{1'b0}};
        end else begin
            if (wrEdge) begin
                case (paddr)
                    `SDC_OFS_DESC_LO: descLo_ff <= pwdata;
                    `SDC_OFS_DESC_HI: descHi_ff <= pwdata;
                    `SDC_OFS_TGT_HI: tgtHi_ff <= pwdata;
                    `SDC_OFS_OFFSET: offset_ff <= pwdata;
                    `SDC_OFS_CTRL: ctrl_ff <= pwdata[`SDC_CTRL_WIDTH-1:0];
                    default: ;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // The check itself, one cycle after the start write
    // ----------------------------------------------------------------
    // Accessed flag only exists in code and data descriptors
    wire [31:0] wbackNext = isSeg ? (descHi_ff | (32'h0000_0001 << `SDC_HI_ACCESSED)) : descHi_ff;
    wire [31:0] stackCeil = bigFlag ? `SDC_STK_LIMIT_WIDE : `SDC_STK_LIMIT_NARROW;

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            startPend_ff <= 1'b0;
            status_ff <= `SDC_RESET_WORD;
            base_ff <= `SDC_RESET_WORD;
            limit_ff <= `SDC_RESET_WORD;
            wback_ff <= `SDC_RESET_WORD;
            stkLim_ff <= `SDC_RESET_WORD;
        end else begin
            // A new start clears done so software never reads stale results
            if (wrEdge && (paddr == `SDC_OFS_CTRL) && pwdata[`SDC_CTRL_START]) begin
                startPend_ff <= 1'b1;
                status_ff <= `SDC_RESET_WORD;
            end else if (startPend_ff) begin
                startPend_ff <= 1'b0;
                status_ff <= nxt_status;
                base_ff <= effBase;
                limit_ff <= effLimit;
                wback_ff <= wbackNext;
                stkLim_ff <= stackCeil;
            end
        end
    end

endmodule

/* File: tb/sdc_desc_table.sv */
/*
 Memory-resident descriptor table seen from the far side of the checker.
 Assumes the bench stores an entry, lets one edge pass, then fetches it.
*/
module sdc_desc_table (
    input wire logic mclk,
    input wire logic wrEn,
    input wire logic [5:0] idx,
    input wire logic [31:0] wrLo,
    input wire logic [31:0] wrHi,
    output logic [31:0] rdLo,
    output logic [31:0] rdHi
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] loMem_ff [0:63];
    logic [31:0] hiMem_ff [0:63];
    always @(posedge mclk) begin
        if (wrEn) begin
            loMem_ff[idx] <= wrLo;
            hiMem_ff[idx] <= wrHi;
        end
    end
    // Fetch is combinational, as a table read finished before the hand-over
    assign rdLo = loMem_ff[idx];
    assign rdHi = hiMem_ff[idx];
endmodule

/* File: tb/sdc_segment_descriptor_checker_chk.sv */
/*
 Port checker: APB timing and sanity of decoded results.
 Assumes it is bound to the top module and sees only its ports.
*/
module sdc_apb_chk (
    input wire mclk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    wire stRead = pready && !pwrite && paddr == 8'h14;
    wire badAddr = paddr[1:0] != 2'b00 || paddr > 8'h24;
    sequence sSetup; psel && !penable; endsequence
    sequence sAccess; psel && penable; endsequence
    chk_one_wait: assert property (sSetup ##1 sAccess |=> pready)
        else $error("ready late");
    chk_ready_cause: assert property (pready |-> $past(psel && penable) && psel && penable)
        else $error("ready without access");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready too long");
    chk_err_paired: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_bad_addr: assert property (pready && badAddr |-> pslverr)
        else $error("bad address accepted");
    chk_good_addr: assert property (pready && !badAddr |-> !pslverr)
        else $error("good address refused");
    chk_rdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
        else $error("read data moved");
    chk_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_stack_limit: assert property (pready && !pwrite && paddr == 8'h24 |->
        prdata == 32'hFFFF_FFFF || prdata == 32'h0000_FFFF) else $error("stack limit");
    chk_fault_vector: assert property (stRead |-> prdata[1] == (prdata[30:26] != 5'h00) &&
        prdata[30:26] inside {5'h00, 5'h0B, 5'h0D}) else $error("fault vector");
    chk_code_readonly: assert property (stRead && prdata[6] |-> !prdata[4])
        else $error("code writable");
    chk_task_offset: assert property (stRead && prdata[15] |-> !prdata[11] && prdata[22:18] == 5'h00)
        else $error("task gate fields");
endmodule
bind sdc_segment_descriptor_checker sdc_apb_chk u_chk (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* File: tb/sdc_segment_descriptor_checker_tb.sv */
/*
 Self-checking bench: random descriptors through the table model into the
 checker over APB, compared against a behavioural prediction.
 Assumes the design answers each APB access after one wait state.
*/
module sdc_segment_descriptor_checker_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, reset, psel, penable, pwrite, wrEn, pready, pslverr, err;
    logic [7:0] paddr;
    logic [5:0] idx;
    logic [4:0] ctl;
    logic [31:0] pwdata, prdata, wrLo, wrHi, rdLo, rdHi, rd, lo, hi, tgt, off, lim, st, mk;
    logic [4:0] tgtKind [4] = '{5'h1A, 5'h09, 5'h0B, 5'h12};
    int miscompares, samplesChecked;
    sdc_segment_descriptor_checker dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    sdc_desc_table tbl (.mclk(mclk), .wrEn(wrEn), .idx(idx), .wrLo(wrLo), .wrHi(wrHi), .rdLo(rdLo), .rdHi(rdHi));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task testDone;
        $display("checks %0d mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samplesChecked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            miscompares++;
        end
    endtask
    // ----------------------------------------------------------------
    // APB master: holds the request until ready is sampled high
    // ----------------------------------------------------------------
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            miscompares++;
            testDone;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task predict;
        logic s, code, wr, tg, gate, task_state_segment, ok;
        logic [3:0] t;
        logic [4:0] v;
        t = hi[11:8];
        s = hi[12];
        code = s && hi[11];
        wr = s && !hi[11] && hi[9];
        tg = !s && t == 4'h5;
        gate = !s && t inside {4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
        task_state_segment = !s && t inside {4'h1, 4'h3, 4'h9, 4'hB};
        lim = hi[23] ? {hi[19:16], lo[15:0], 12'hFFF} : {12'h000, hi[19:16], lo[15:0]};
        ok = (s && !hi[11] && hi[10]) ? off > lim : off <= lim;
        v = 5'h00;
        if (!s && (t inside {4'h0, 4'h8, 4'hD} || (t == 4'h2 && !ctl[1]))) v = 5'h0D;
        else if (!hi[15]) v = 5'h0B;
        else if (gate && (tg ? !(!tgt[12] && tgt[11:8] inside {4'h1, 4'h3, 4'h9, 4'hB}) : !(tgt[12] && tgt[11])))
            v = 5'h0D;
        else if (s && (((ctl[2] || ctl[3]) && !wr) || !ok)) v = 5'h0D;
        st = {1'b0, v, 3'b000, (!s && t[1:0] == 2'b00 && t[2] && ctl[4]) ? hi[4:0] : 5'h00, 1'b0,
            !s && t[3], tg, !s && t == 4'h2, task_state_segment, gate, !tg, ok, !s && hi[31:16] == 16'h0000,
            !s && (t == 4'h6 || t == 4'hE), s && hi[22], code, code ? hi[9] : 1'b1, wr, code && hi[10],
            s && hi[22], v != 5'h00, 1'b1};
        // Readable and range bits of system descriptors, wide bit of segments, are left open
        mk = s ? 32'hFFFE_FFFF : 32'hFFFF_FBDF;
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, wrEn, idx, wrLo, wrHi} = '0;
        reset = 1'b1;
        miscompares = 0;
        samplesChecked = 0;
        void'($urandom(32));
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        apb(1'b0, 8'h14, 0);
        chk("status at reset", 0, rd);
        for (int i = 0; i < 64; i++) begin
            hi = $urandom;
            hi[15] = ($urandom % 4) != 0;
            if (i < 32) hi[12:8] = {1'b0, i[3:0]};
            else hi[12] = 1'b1;
            if (i >= 16 && i < 32) hi[31:16] = 16'h0000;
            @(posedge mclk);
            wrEn <= 1'b1;
            idx <= i[5:0];
            wrLo <= $urandom;
            wrHi <= hi;
            @(posedge mclk);
            wrEn <= 1'b0;
            @(posedge mclk);
            lo = rdLo;
            hi = rdHi;
            tgt = $urandom;
            tgt[12:8] = tgtKind[$urandom % 4];
            ctl = 5'($urandom) | 5'h01;
            off = $urandom % 32'h0001_0000;
            predict;
            if (i % 3 == 0 && lim < 32'h0000_FFFF) off = lim + 32'(i[0]);
            predict;
            apb(1'b1, 8'h00, lo);
            apb(1'b1, 8'h04, hi);
            apb(1'b1, 8'h0C, tgt);
            apb(1'b1, 8'h10, off);
            apb(1'b1, 8'h08, 32'(ctl));
            apb(1'b0, 8'h14, 0);
            chk("status", st & mk, rd & mk);
            apb(1'b0, 8'h18, 0);
            chk("base", {hi[31:24], hi[7:0], lo[31:16]}, rd);
            apb(1'b0, 8'h1C, 0);
            chk("limit", lim, rd);
            apb(1'b0, 8'h20, 0);
            chk("write-back", hi[12] ? hi | 32'h0000_0100 : hi, rd);
            apb(1'b0, 8'h24, 0);
            chk("stack limit", hi[22] ? 32'hFFFF_FFFF : 32'h0000_FFFF, rd);
        end
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        apb(1'b0, 8'h14, 0);
        chk("status kept", st & mk, rd & mk);
        apb(1'b0, 8'h28, 0);
        chk("unmapped error", 1, err);
        chk("unmapped data", 0, rd);
        apb(1'b1, 8'h02, 32'h1234_5678);
        chk("unaligned error", 1, err);
        apb(1'b0, 8'h00, 0);
        chk("low word kept", lo, rd);
        testDone;
    end
endmodule
